// *** design/asrc_consts.vh ***
// Operation
// - Both strobes low start; either high ends
// - Write strobe stays high throughout reads
// - Address valid before select falls; the sequencer sets address and select on the same clock edge
// - Clear: clear and select low, min 10 ns
// - Strobe high, select, address before clear; select and address change on the same clock edge that starts clear
// - Strobe high 8 ns after clear ends
// - Address held 10 ns after clear ends
`ifndef ASRC_CONSTS_VH
`define ASRC_CONSTS_VH
`define ASRC_CLK_NS 10
`define ASRC_ADDR_W 10
`define ASRC_DATA_W 4
// timing figures in ns
`define ASRC_CLEAR_PULSE_MIN_NS 10
`define ASRC_WSTROBE_HOLD_AFTER_CLEAR_NS 8
`define ASRC_ADDR_HOLD_AFTER_CLEAR_NS 10
`define ASRC_ACCESS_NS 10
`define ASRC_WRITE_PULSE_NS 6
`define ASRC_SETUP_NS 2
`define ASRC_HOLD_NS 2
// least times, rounded up to cycles
`define ASRC_CYC(ns) ((((ns) + `ASRC_CLK_NS - 1) / `ASRC_CLK_NS) < 1 ? 1 : (((ns) + `ASRC_CLK_NS - 1) / `ASRC_CLK_NS))
`define ASRC_CLEAR_CYC `ASRC_CYC(`ASRC_CLEAR_PULSE_MIN_NS)
`define ASRC_WHOLD_CYC `ASRC_CYC(`ASRC_WSTROBE_HOLD_AFTER_CLEAR_NS)
`define ASRC_AHOLD_CYC `ASRC_CYC(`ASRC_ADDR_HOLD_AFTER_CLEAR_NS)
`define ASRC_ACCESS_CYC `ASRC_CYC(`ASRC_ACCESS_NS)
`define ASRC_WPULSE_CYC `ASRC_CYC(`ASRC_WRITE_PULSE_NS)
`define ASRC_SETUP_CYC `ASRC_CYC(`ASRC_SETUP_NS)
`define ASRC_HOLD_CYC `ASRC_CYC(`ASRC_HOLD_NS)
// read data needs the synchroniser depth on top of the access time
`define ASRC_SYNC_MARGIN_CYC 4
// operation codes
`define ASRC_OP_READ 2'h0
`define ASRC_OP_WRITE 2'h1
`define ASRC_OP_CLEAR 2'h2
`endif

// *** design/asrc_sync.v ***
`timescale 1ns/1ps
`default_nettype none
// three-stage synchroniser; change accepted once stages two and three agree
module asrc_sync #(
  parameter W = 4
) (
  // clock and reset
  input wire clk,
  input wire reset_n,
  // data
  input wire [W-1:0] din,
  output reg [W-1:0] dout
);
  reg [W-1:0] s1_r;
  reg [W-1:0] s2_r;
  reg [W-1:0] s3_r;
  always @(posedge clk) begin
    if (!reset_n) begin
      s1_r <= {W{1'b0}};
      s2_r <= {W{1'b0}};
      s3_r <= {W{1'b0}};
      dout <= {W{1'b0}};
    end else begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        dout <= s3_r;
      end
    end
  end
endmodule // asrc_sync
`default_nettype wire

// *** design/asrc_ctrl.v ***
`timescale 1ns/1ps
`default_nettype none
`include "asrc_consts.vh"
module asrc_ctrl #(
  parameter AW = `ASRC_ADDR_W,
  parameter DW = `ASRC_DATA_W
) (
  // clock and reset
  input wire clk,
  input wire reset_n,
  // user request
  input wire req_valid,
  output wire req_ready,
  input wire [1:0] req_op,
  input wire [AW-1:0] req_addr,
  input wire [DW-1:0] req_wdata,
  // user answer
  output wire rsp_valid,
  output wire [DW-1:0] rsp_rdata,
  // memory pins
  output wire mem_cs_n,
  output wire mem_we_n,
  output wire mem_oe_n,
  output wire array_clear_n,
  output wire [AW-1:0] mem_addr,
  output wire [DW-1:0] mem_din,
  input wire [DW-1:0] mem_dout
);
  // sequencer states
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_SETUP = 3'h1;
  localparam [2:0] ST_STROBE = 3'h2;
  localparam [2:0] ST_HOLD = 3'h3;
  localparam [2:0] ST_READ = 3'h4;
  localparam [2:0] ST_CLEAR = 3'h5;
  localparam [2:0] ST_RECOVER = 3'h6;

  // least times in whole cycles
  localparam integer SETUP_I = `ASRC_SETUP_CYC;
  localparam integer WPULSE_I = `ASRC_WPULSE_CYC;
  localparam integer HOLD_I = `ASRC_HOLD_CYC;
  localparam integer READ_I = `ASRC_ACCESS_CYC + `ASRC_SYNC_MARGIN_CYC;
  // two pulse widths to cover the two-cycle clear
  localparam integer CLEAR_I = 2 * `ASRC_CLEAR_CYC;
  localparam integer WHOLD_I = `ASRC_WHOLD_CYC;
  localparam integer AHOLD_I = `ASRC_AHOLD_CYC;
  // recovery must cover the longer of the two after-clear holds
  localparam integer RECOVER_I = (WHOLD_I > AHOLD_I) ? WHOLD_I : AHOLD_I;
  // cut to the counter width on purpose; every count is far below 256
  localparam [7:0] C_SETUP = SETUP_I[7:0];
  localparam [7:0] C_WPULSE = WPULSE_I[7:0];
  localparam [7:0] C_HOLD = HOLD_I[7:0];
  localparam [7:0] C_READ = READ_I[7:0];
  localparam [7:0] C_CLEAR = CLEAR_I[7:0];
  localparam [7:0] C_RECOVER = RECOVER_I[7:0];

  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [7:0] cnt_r;
  reg [7:0] cnt_nxt;
  reg rsp_valid_r;
  reg rsp_valid_nxt;
  reg [DW-1:0] rsp_rdata_r;
  reg [DW-1:0] rsp_rdata_nxt;
  reg cs_n_r;
  reg cs_n_nxt;
  reg we_n_r;
  reg we_n_nxt;
  reg oe_n_r;
  reg oe_n_nxt;
  reg clr_n_r;
  reg clr_n_nxt;
  reg [AW-1:0] addr_r;
  reg [AW-1:0] addr_nxt;
  reg [DW-1:0] din_r;
  reg [DW-1:0] din_nxt;
  wire [7:0] cnt_inc;
  wire [DW-1:0] dout_sync;

  // one decode of the request code, shared by the state and pin choice
  function [2:0] op_to_state;
    input [1:0] op;
    begin
      case (op)
        `ASRC_OP_WRITE: begin
          op_to_state = ST_SETUP;
        end
        `ASRC_OP_CLEAR: begin
          op_to_state = ST_CLEAR;
        end
        default: begin
          // the spare code reads, so no request can stall the sequencer
          op_to_state = ST_READ;
        end
      endcase
    end
  endfunction

  // read data comes from pins, so it crosses into clk first
  asrc_sync #(.W(DW)) u_sync (
    .clk(clk),
    .reset_n(reset_n),
    .din(mem_dout),
    .dout(dout_sync)
  );

  assign cnt_inc = cnt_r + 8'h01;
  assign req_ready = (state_r == ST_IDLE);
  assign rsp_valid = rsp_valid_r;
  assign rsp_rdata = rsp_rdata_r;
  assign mem_cs_n = cs_n_r;
  assign mem_we_n = we_n_r;
  assign mem_oe_n = oe_n_r;
  assign array_clear_n = clr_n_r;
  assign mem_addr = addr_r;
  assign mem_din = din_r;

  always @* begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    rsp_valid_nxt = 1'b0;
    rsp_rdata_nxt = rsp_rdata_r;
    cs_n_nxt = cs_n_r;
    we_n_nxt = we_n_r;
    oe_n_nxt = oe_n_r;
    clr_n_nxt = clr_n_r;
    addr_nxt = addr_r;
    din_nxt = din_r;
    case (state_r)
      ST_IDLE: begin
        cs_n_nxt = 1'b1;
        // strobe stays high into any clear, so nothing is stored then
        we_n_nxt = 1'b1;
        oe_n_nxt = 1'b1;
        clr_n_nxt = 1'b1;
        if (req_valid) begin
          // address placed with or before select falls
          addr_nxt = req_addr;
          din_nxt = req_wdata;
          cnt_nxt = 8'h00;
          cs_n_nxt = 1'b0;
          state_nxt = op_to_state(req_op);
          case (op_to_state(req_op))
            ST_CLEAR: begin
              // select low and address valid at clear start
              clr_n_nxt = 1'b0;
            end
            ST_READ: begin
              // write strobe stays high for the whole read
              oe_n_nxt = 1'b0;
            end
            default: begin
              // write strobe opens a cycle later so the address leads it
              we_n_nxt = 1'b1;
            end
          endcase
        end
      end
      ST_SETUP: begin
        // address settles before the write opens
        if (cnt_inc >= C_SETUP) begin
          we_n_nxt = 1'b0;
          cnt_nxt = 8'h00;
          state_nxt = ST_STROBE;
        end else begin
          cnt_nxt = cnt_inc;
        end
      end
      ST_STROBE: begin
        // data already stable; strobe rise ends the write
        if (cnt_inc >= C_WPULSE) begin
          we_n_nxt = 1'b1;
          cnt_nxt = 8'h00;
          state_nxt = ST_HOLD;
        end else begin
          cnt_nxt = cnt_inc;
        end
      end
      ST_HOLD: begin
        // data and address held past the ending edge
        if (cnt_inc >= C_HOLD) begin
          cs_n_nxt = 1'b1;
          rsp_valid_nxt = 1'b1;
          state_nxt = ST_IDLE;
        end else begin
          cnt_nxt = cnt_inc;
        end
      end
      ST_READ: begin
        // wait access time plus the synchroniser depth
        if (cnt_r >= C_READ) begin
          rsp_rdata_nxt = dout_sync;
          rsp_valid_nxt = 1'b1;
          cs_n_nxt = 1'b1;
          oe_n_nxt = 1'b1;
          state_nxt = ST_IDLE;
        end else begin
          cnt_nxt = cnt_inc;
        end
      end
      ST_CLEAR: begin
        if (cnt_inc >= C_CLEAR) begin
          clr_n_nxt = 1'b1;
          cnt_nxt = 8'h00;
          state_nxt = ST_RECOVER;
        end else begin
          cnt_nxt = cnt_inc;
        end
      end
      ST_RECOVER: begin
        // keep strobe high and address frozen after clear
        if (cnt_inc >= C_RECOVER) begin
          cs_n_nxt = 1'b1;
          rsp_valid_nxt = 1'b1;
          state_nxt = ST_IDLE;
        end else begin
          cnt_nxt = cnt_inc;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk) begin
    if (!reset_n) begin
      state_r <= ST_IDLE;
      cnt_r <= 8'h00;
      rsp_valid_r <= 1'b0;
      rsp_rdata_r <= {DW{1'b0}};
      cs_n_r <= 1'b1;
      we_n_r <= 1'b1;
      oe_n_r <= 1'b1;
      clr_n_r <= 1'b1;
      addr_r <= {AW{1'b0}};
      din_r <= {DW{1'b0}};
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      rsp_valid_r <= rsp_valid_nxt;
      rsp_rdata_r <= rsp_rdata_nxt;
      cs_n_r <= cs_n_nxt;
      we_n_r <= we_n_nxt;
      oe_n_r <= oe_n_nxt;
      clr_n_r <= clr_n_nxt;
      addr_r <= addr_nxt;
      din_r <= din_nxt;
    end
  end
endmodule // asrc_ctrl
`default_nettype wire

// *** testbench/asrc_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module asrc_assertions #(
  parameter AW = 10
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // memory pins
  input wire logic mem_cs_n,
  input wire logic mem_we_n,
  input wire logic mem_oe_n,
  input wire logic array_clear_n,
  input wire logic [AW-1:0] mem_addr
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence wr_pulse;
    !mem_we_n ##1 mem_we_n;
  endsequence
  chk_write_shape: assert property ($fell(mem_we_n) |-> (wr_pulse and !mem_cs_n [*2]) ##1 mem_cs_n)
    else $error("write strobe shape");
  chk_read_we_high: assert property (!mem_oe_n |-> mem_we_n && !mem_cs_n && array_clear_n)
    else $error("read with write strobe");
  chk_addr_held: assert property (!mem_cs_n && $past(!mem_cs_n) |-> $stable(mem_addr))
    else $error("address moved while selected");
  sequence clr_pulse;
    (!array_clear_n && !mem_cs_n) [*2] ##1 array_clear_n;
  endsequence
  chk_clear_width: assert property ($fell(array_clear_n) |-> clr_pulse)
    else $error("clear pulse width");
  chk_clear_setup: assert property (!array_clear_n |-> mem_we_n && !mem_cs_n)
    else $error("clear without select");
  chk_clear_we_hold: assert property ($rose(array_clear_n) |-> mem_we_n ##1 mem_we_n)
    else $error("write strobe too soon");
  chk_clear_addr: assert property ($rose(array_clear_n) |-> $stable(mem_addr) ##1 $stable(mem_addr))
    else $error("address moved after clear");
endmodule // asrc_assertions
`default_nettype wire

// *** testbench/asrc_sram_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module asrc_sram_model #(
  parameter DLY = 8
) (
  // strobes
  input wire logic cs_n,
  input wire logic we_n,
  input wire logic oe_n,
  input wire logic clr_n,
  // address and data
  input wire logic [9:0] a,
  input wire logic [3:0] d,
  output logic [3:0] q
);
  logic [3:0] m [1024];
  always @(posedge cs_n) if (!we_n && clr_n) m[a] <= d;
  always @(posedge we_n) if (!cs_n && clr_n) m[a] <= d;
  always @(negedge clr_n or negedge cs_n) if (!clr_n && !cs_n) foreach (m[i]) m[i] = 4'h0;
  // a floating bus shows inverted data, never a stable guess
  assign #DLY q = (!cs_n && we_n && !oe_n && clr_n) ? m[a] : ~m[a];
endmodule // asrc_sram_model
`default_nettype wire

// *** testbench/asrc_ctrl_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module asrc_ctrl_tb_top;
  logic clk = 0, reset_n = 0, req_valid = 0, req_ready, rsp_valid;
  logic [1:0] req_op = 0;
  logic [9:0] req_addr = 0, mem_addr;
  logic [3:0] req_wdata = 0, rsp_rdata, mem_din, mem_dout;
  logic mem_cs_n, mem_we_n, mem_oe_n, array_clear_n;
  int miscompares = 0, compares = 0;
  // op, address, write data, expected read data
  logic [19:0] rows [8] = '{{2'h2, 10'h000, 8'h00}, {2'h1, 10'h3ff, 8'ha0}, {2'h1, 10'h000, 8'h60},
    {2'h0, 10'h3ff, 8'h0a}, {2'h0, 10'h000, 8'h06}, {2'h3, 10'h3ff, 8'h0a}, {2'h0, 10'h155, 8'h00},
    {2'h1, 10'h155, 8'hc0}};
  always #5 clk = ~clk;
  asrc_ctrl i_dut (.clk(clk), .reset_n(reset_n), .req_valid(req_valid), .req_ready(req_ready), .req_op(req_op),
    .req_addr(req_addr), .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .mem_cs_n(mem_cs_n),
    .mem_we_n(mem_we_n), .mem_oe_n(mem_oe_n), .array_clear_n(array_clear_n), .mem_addr(mem_addr),
    .mem_din(mem_din), .mem_dout(mem_dout));
  asrc_sram_model i_mem (.cs_n(mem_cs_n), .we_n(mem_we_n), .oe_n(mem_oe_n), .clr_n(array_clear_n),
    .a(mem_addr), .d(mem_din), .q(mem_dout));
  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic run_op(input logic [19:0] r);
    int n;
    n = 0;
    @(negedge clk);
    {req_op, req_addr, req_wdata} = r[19:4];
    req_valid = 1'b1;
    @(negedge clk);
    req_valid = 1'b0;
    chk({3'h0, req_ready}, 4'h0);
    while (rsp_valid !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    if (n == 40) begin
      miscompares++;
      print_verdict();
    end else if (r[19:18] != 2'h1 && r[19:18] != 2'h2) begin
      chk(rsp_rdata, r[3:0]);
    end
  endtask
  initial begin
    repeat (5) @(negedge clk);
    reset_n = 1'b1;
    foreach (rows[i]) run_op(rows[i]);
    run_op({2'h2, 10'h155, 8'h00});
    run_op({2'h0, 10'h155, 8'h00});
    @(negedge clk);
    reset_n = 1'b0;
    repeat (4) @(negedge clk);
    chk({mem_cs_n, mem_we_n, mem_oe_n, array_clear_n}, 4'hf);
    reset_n = 1'b1;
    run_op({2'h1, 10'h2aa, 8'h90});
    run_op({2'h0, 10'h2aa, 8'h09});
    print_verdict();
  end
endmodule // asrc_ctrl_tb_top
bind asrc_ctrl asrc_assertions #(.AW(AW)) i_chk (.clk(clk), .reset_n(reset_n), .mem_cs_n(mem_cs_n),
  .mem_we_n(mem_we_n), .mem_oe_n(mem_oe_n), .array_clear_n(array_clear_n), .mem_addr(mem_addr));
`default_nettype wire
